// ==== rtl/ochr_pkg.sv ====
// Shared constants, state type and helpers of the overcurrent hiccup retry block
package ochr_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SS_TIME_NS     = 13600000;
  localparam int SS_STEPS       = 64;
  localparam int SS_STEP_CYC    = SS_TIME_NS / SS_STEPS / CLK_PERIOD_NS;
  localparam int INIT_DELAY_NS  = 6800000;
  localparam int INIT_DELAY_CYC = INIT_DELAY_NS / CLK_PERIOD_NS;
  localparam int BOOT_ON_NS     = 100000;
  localparam int BOOT_ON_CYC    = BOOT_ON_NS / CLK_PERIOD_NS;
  localparam int SW_FREQ_HZ     = 300000;
  localparam int SW_PERIOD_CYC  = 1000000000 / (SW_FREQ_HZ * CLK_PERIOD_NS);
  localparam int LS_MIN_NS      = 425;
  localparam int LS_MIN_CYC     = (LS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_NS       = 200;
  localparam int BLANK_CYC      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_MIN_NS  = 27200000;
  localparam int HICCUP_MAX_NS  = 40800000;
  localparam int DUMMY_CYCLES   = 2;
  localparam int NARROW_RUN     = 3;

  // ********************************************************************
  // Widths, thresholds and sync bit positions
  // ********************************************************************
  localparam int CNT_W       = 20;
  localparam int OFF_W       = 23;
  localparam int SW_W        = 9;
  localparam int MV_W        = 10;
  localparam int SS_LVL_W    = 7;
  localparam int SYNC_W      = 4;
  localparam int IDX_PWM     = 0;
  localparam int IDX_OC      = 1;
  localparam int IDX_EN_LOW  = 2;
  localparam int IDX_OPEN    = 3;
  localparam logic [MV_W-1:0]     OCP_DET_MAX_MV = 10'd475;
  localparam logic [MV_W-1:0]     OCP_DIS_MV     = 10'd300;
  localparam logic [SS_LVL_W-1:0] SS_FULL        = 7'h40;

  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_INIT_DELAY,
    ST_SAMPLE,
    ST_SOFTSTART,
    ST_REGULATE,
    ST_DUMMY
  } ochr_state_t;

  // Trip level seen at the switch node is twice the resistor drop, clamped
  function automatic logic [MV_W-1:0] ochr_setpoint(input logic [MV_W-1:0] mv);
    logic [MV_W:0] dbl;
    dbl = {mv, 1'b0};
    return (dbl > {1'b0, OCP_DET_MAX_MV}) ? OCP_DET_MAX_MV : dbl[MV_W-1:0];
  endfunction : ochr_setpoint

  function automatic logic [5:0] ochr_sat_inc(input logic [5:0] v, input logic [5:0] lim);
    return (v >= lim) ? lim : 6'(v + 6'h01);
  endfunction : ochr_sat_inc

endpackage : ochr_pkg

// ==== rtl/ochr_ss_if.sv ====
// Link between the sequencer and its soft-start ramp timer
`timescale 1ns/1ps
interface ochr_ss_if;
  import ochr_pkg::*;
  logic                start;
  logic                clear;
  logic                done;
  logic                active;
  logic [SS_LVL_W-1:0] level;
  modport ctrl (output start, output clear, input done, input active, input level);
  modport ramp (input start, input clear, output done, output active, output level);
endinterface : ochr_ss_if

// ==== rtl/ochr_ramp.sv ====
// Digital soft-start ramp, also used as the dummy time-out timer
`timescale 1ns/1ps
module ochr_ramp
  import ochr_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = ochr_pkg::SS_STEP_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  ochr_ss_if.ramp   ss
);
  import ochr_pkg::*;

  typedef struct packed {
    logic                active;
    logic [CNT_W-1:0]    cnt;
    logic [SS_LVL_W-1:0] level;
  } ochr_ramp_t;

  localparam logic [CNT_W-1:0]    STEP_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [SS_LVL_W-1:0] LVL_LAST  = SS_FULL - 7'h01;

  ochr_ramp_t st_ff;
  ochr_ramp_t nxt_st;

  // ********************************************************************
  // Ramp steps
  // ********************************************************************
  always_comb begin
    nxt_st      = st_ff;
    if (ss.clear) begin
      nxt_st = '0;
    end else if (ss.start) begin
      nxt_st.active = 1'b1;
      nxt_st.cnt    = '0;
      nxt_st.level  = '0;
    end else if (st_ff.active) begin
      if (st_ff.cnt == STEP_LAST) begin
        nxt_st.cnt   = '0;
        nxt_st.level = st_ff.level + 7'h01;
        if (st_ff.level == LVL_LAST) begin
          nxt_st.active = 1'b0;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Done marks the last cycle of a run, so a back-to-back restart adds no idle cycle
  assign ss.done   = st_ff.active && (st_ff.cnt == STEP_LAST) && (st_ff.level == LVL_LAST);
  assign ss.active = st_ff.active;
  assign ss.level  = st_ff.level;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_RAMP_STEP: assert property (
    (st_ff.level != $past(st_ff.level)) |->
      (st_ff.level == $past(st_ff.level) + 7'h01) || (st_ff.level == '0))
    else $error("ramp level moved by other than one step");

endmodule : ochr_ramp

// ==== rtl/ochr_top.sv ====
// Overcurrent hiccup retry, enable shutdown and gate housekeeping sequencer
`timescale 1ns/1ps
// What this block does
// - Sampled trip level is double the resistor drop, within 0 to 475 mV.
// - Resistor drop above 0.3 V, or no resistor, disables overcurrent protection.
// - On overcurrent, turn output off and run two soft-start-long delays.
// - After both delays ramp normally; a trip during the ramp returns to delays.
// - A trip in the real ramp starts a fresh pair of delays at once, forever.
// - Whole hiccup period lies between 27.2 ms and 40.8 ms.
// - Overcurrent detection stays active in every soft-start, first start included.
// - With the short gone, the next real ramp completes and regulation resumes.
// - High-side gate on for 100 us forces low-side gate on one switching cycle.
// - Boot refresh still works with protection and pulse stretching disabled.
// - Enable pin below 0.4 V holds shutdown.
// - Three narrow or missing low-side pulses: third stretched to 425 ns.
// - Trip level is not resampled in retries, only after full initialization.
// - Soft-start reference climbs digitally in 64 equal steps.
// - Current sensing starts 200 ns after low-side rise, ends at its fall.
module ochr_top
  import ochr_pkg::*;
#(
  parameter int unsigned SS_STEP_CYCLES    = ochr_pkg::SS_STEP_CYC,
  parameter int unsigned INIT_DELAY_CYCLES = ochr_pkg::INIT_DELAY_CYC,
  parameter int unsigned BOOT_ON_CYCLES    = ochr_pkg::BOOT_ON_CYC
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          pwm_in,
  input  wire logic                          oc_cmp_in,
  input  wire logic                          en_low_in,
  input  wire logic                          rbsoc_open_in,
  input  wire logic [ochr_pkg::MV_W-1:0]     rbsoc_mv_in,
  output logic                               high_side_gate_out,
  output logic                               low_side_gate_out,
  output logic                               ocp_set_current_source_en_out,
  output logic                               overcurrent_protect_en_out,
  output logic [ochr_pkg::MV_W-1:0]          ocp_set_current_mv_out,
  output logic [ochr_pkg::SS_LVL_W-1:0]      ss_ref_out,
  output logic                               regulating_out,
  output logic                               hiccup_out
);
  import ochr_pkg::*;

  typedef struct packed {
    ochr_state_t         state;
    logic [CNT_W-1:0]    cnt;
    logic                dummy_idx;
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;
    logic [MV_W-1:0]     mv1;
    logic [MV_W-1:0]     mv2;
    logic [MV_W-1:0]     setpoint;
    logic                ocp_en;
    logic                hs;
    logic                ls;
    logic [SW_W-1:0]     sw_cnt;
    logic [5:0]          ls_width;
    logic [5:0]          ls_on;
    logic [1:0]          narrow_cnt;
    logic [5:0]          stretch;
    logic [SW_W-1:0]     refresh;
    logic [CNT_W-1:0]    hs_cnt;
    logic [SS_LVL_W-1:0] ref_lvl;
  } ochr_top_t;

  localparam logic [CNT_W-1:0] INIT_LAST  = CNT_W'(INIT_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] BOOT_LAST  = CNT_W'(BOOT_ON_CYCLES - 1);
  localparam logic [SW_W-1:0]  SW_LAST    = SW_W'(SW_PERIOD_CYC - 1);
  localparam logic [SW_W-1:0]  SW_PERIOD  = SW_W'(SW_PERIOD_CYC);
  localparam logic [5:0]       LS_MIN     = 6'(LS_MIN_CYC);
  localparam logic [5:0]       BLANK      = 6'(BLANK_CYC);
  localparam logic [1:0]       NARROW_ARM = 2'(NARROW_RUN - 2);
  localparam logic [OFF_W-1:0] OFF_LAST   = OFF_W'(DUMMY_CYCLES * SS_STEPS * SS_STEP_CYCLES - 1);

  ochr_top_t   st_ff;
  ochr_top_t   nxt_st;
  ochr_ss_if   ss_link ();
  logic        ss_start;
  logic        ss_clear;
  logic        pwm_s;
  logic        oc_s;
  logic        en_low_s;
  logic        open_s;
  logic        switching;
  logic        gate_en;
  logic        oc_trip;
  logic        sw_tick;
  logic        force_ls;
  logic        boot_fire;
  logic        stretch_fire;

  ochr_ramp #(
    .STEP_CYCLES (SS_STEP_CYCLES)
  ) u_ramp (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ss     (ss_link.ramp)
  );

  assign ss_link.start = ss_start;
  assign ss_link.clear = ss_clear;

  // Only the second sync stage is looked at
  assign pwm_s     = st_ff.sync2[IDX_PWM];
  assign oc_s      = st_ff.sync2[IDX_OC];
  assign en_low_s  = st_ff.sync2[IDX_EN_LOW];
  assign open_s    = st_ff.sync2[IDX_OPEN];
  assign switching = (st_ff.state == ST_SOFTSTART) || (st_ff.state == ST_REGULATE);
  assign sw_tick   = (st_ff.sw_cnt == SW_LAST);
  assign force_ls  = (st_ff.stretch != '0) || (st_ff.refresh != '0);
  // Window opens after the blanking time so ringing after the edge is ignored
  assign oc_trip   = switching && st_ff.ocp_en && st_ff.ls && (st_ff.ls_on >= BLANK)
                     && oc_s;

  // ********************************************************************
  // Sequencer and gate housekeeping
  // ********************************************************************
  always_comb begin
    nxt_st       = st_ff;
    ss_start     = 1'b0;
    ss_clear     = 1'b0;
    boot_fire    = 1'b0;
    stretch_fire = 1'b0;
    // The resistor drop is static while sampled, so plain two-stage sync is enough
    nxt_st.sync1 = {rbsoc_open_in, en_low_in, oc_cmp_in, pwm_in};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.mv1   = rbsoc_mv_in;
    nxt_st.mv2   = st_ff.mv1;
    case (st_ff.state)
      ST_SHUTDOWN: begin
        nxt_st.state = ST_INIT_DELAY;
        nxt_st.cnt   = '0;
      end
      ST_INIT_DELAY: begin
        nxt_st.cnt = st_ff.cnt + 20'h00001;
        if (st_ff.cnt == INIT_LAST) begin
          nxt_st.state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        nxt_st.setpoint = ochr_setpoint(st_ff.mv2);
        nxt_st.ocp_en   = !open_s && (st_ff.mv2 <= OCP_DIS_MV);
        nxt_st.state    = ST_SOFTSTART;
        ss_start        = 1'b1;
      end
      ST_SOFTSTART: begin
        if (oc_trip) begin
          nxt_st.state     = ST_DUMMY;
          nxt_st.dummy_idx = 1'b0;
          ss_start         = 1'b1;
        end else if (ss_link.done) begin
          nxt_st.state = ST_REGULATE;
        end
      end
      ST_REGULATE: begin
        if (oc_trip) begin
          nxt_st.state     = ST_DUMMY;
          nxt_st.dummy_idx = 1'b0;
          ss_start         = 1'b1;
        end
      end
      ST_DUMMY: begin
        if (ss_link.done) begin
          ss_start = 1'b1;
          if (st_ff.dummy_idx) begin
            nxt_st.state = ST_SOFTSTART;
          end else begin
            nxt_st.dummy_idx = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.state = ST_SHUTDOWN;
      end
    endcase
    if (en_low_s) begin
      nxt_st.state = ST_SHUTDOWN;
      ss_start     = 1'b0;
      ss_clear     = 1'b1;
    end

    gate_en       = (nxt_st.state == ST_SOFTSTART) || (nxt_st.state == ST_REGULATE);
    nxt_st.sw_cnt = sw_tick ? '0 : SW_W'(st_ff.sw_cnt + 9'h001);
    nxt_st.ls_on  = st_ff.ls ? ochr_sat_inc(st_ff.ls_on, BLANK) : '0;
    if (sw_tick) begin
      nxt_st.ls_width = '0;
      if (st_ff.ls_width < LS_MIN) begin
        if (st_ff.narrow_cnt == NARROW_ARM) begin
          stretch_fire      = st_ff.ocp_en;
          nxt_st.narrow_cnt = '0;
        end else begin
          nxt_st.narrow_cnt = st_ff.narrow_cnt + 2'h1;
        end
      end else begin
        nxt_st.narrow_cnt = '0;
      end
    end else if (st_ff.ls) begin
      nxt_st.ls_width = ochr_sat_inc(st_ff.ls_width, LS_MIN);
    end
    nxt_st.stretch = stretch_fire ? LS_MIN
                   : (st_ff.stretch != '0) ? st_ff.stretch - 6'h01 : '0;
    // Refresh is independent of the protection enable
    boot_fire      = st_ff.hs && (st_ff.hs_cnt == BOOT_LAST);
    nxt_st.hs_cnt  = (st_ff.hs && !boot_fire) ? st_ff.hs_cnt + 20'h00001 : '0;
    nxt_st.refresh = boot_fire ? SW_PERIOD
                   : (st_ff.refresh != '0) ? st_ff.refresh - 9'h001 : '0;
    nxt_st.hs      = gate_en && pwm_s && !force_ls;
    nxt_st.ls      = gate_en && (!pwm_s || force_ls);
    if (!gate_en) begin
      nxt_st.narrow_cnt = '0;
      nxt_st.stretch    = '0;
      nxt_st.refresh    = '0;
    end
    if (nxt_st.state == ST_REGULATE) begin
      nxt_st.ref_lvl = SS_FULL;
    end else if (nxt_st.state == ST_SOFTSTART && st_ff.state == ST_SOFTSTART
                 && ss_link.active) begin
      nxt_st.ref_lvl = ss_link.level;
    end else begin
      nxt_st.ref_lvl = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign high_side_gate_out         = st_ff.hs;
  assign low_side_gate_out          = st_ff.ls;
  assign ocp_set_current_source_en_out         = (st_ff.state == ST_INIT_DELAY) || (st_ff.state == ST_SAMPLE);
  assign overcurrent_protect_en_out = st_ff.ocp_en;
  assign ocp_set_current_mv_out     = st_ff.setpoint;
  assign ss_ref_out                 = st_ff.ref_lvl;
  assign regulating_out             = (st_ff.state == ST_REGULATE);
  assign hiccup_out                 = (st_ff.state == ST_DUMMY);

  // ********************************************************************
  // Checks
  // ********************************************************************
  logic [OFF_W-1:0] off_cnt_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in || st_ff.state != ST_DUMMY) begin
      off_cnt_ff <= '0;
    end else begin
      off_cnt_ff <= off_cnt_ff + 23'h000001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_SETPOINT_RANGE: assert property (
    (st_ff.state == ST_SAMPLE) |=> (st_ff.setpoint <= OCP_DET_MAX_MV)
      && (st_ff.setpoint == ochr_setpoint($past(st_ff.mv2))))
    else $error("trip level not twice the resistor drop within range");
  AST_OCP_DISABLE: assert property (
    (st_ff.state == ST_SAMPLE && (open_s || st_ff.mv2 > OCP_DIS_MV)) |=> !st_ff.ocp_en ##1 !oc_trip)
    else $error("protection left enabled above disable level");
  AST_TRIP_OFF: assert property (
    (oc_trip && !en_low_s) |=> hiccup_out && !st_ff.hs && !st_ff.ls && !st_ff.dummy_idx)
    else $error("output not off after overcurrent");
  AST_TWO_DUMMIES: assert property (
    (st_ff.state == ST_DUMMY && nxt_st.state == ST_SOFTSTART) |-> st_ff.dummy_idx)
    else $error("real ramp started before two delays");
  AST_HICCUP_OFF: assert property (
    (st_ff.state == ST_DUMMY && nxt_st.state == ST_SOFTSTART) |-> (off_cnt_ff == OFF_LAST))
    else $error("retry off time is not two full soft-start lengths");
  AST_SS_TRIP: assert property (
    (st_ff.state == ST_SOFTSTART && oc_trip && !en_low_s) |=> (st_ff.state == ST_DUMMY))
    else $error("trip during soft-start ignored");
  AST_SS_DONE: assert property (
    (st_ff.state == ST_SOFTSTART && ss_link.done && !oc_trip && !en_low_s) |=> regulating_out
      && (ss_ref_out == SS_FULL))
    else $error("clean ramp did not resume regulation");
  AST_BOOT_REFRESH: assert property (
    boot_fire |=> ##1 (!st_ff.hs && (st_ff.ls || !switching)) [*8])
    else $error("long high-side on-time did not force low-side gate");
  AST_BOOT_NO_OCP: assert property (
    (boot_fire && !st_ff.ocp_en) |=> (st_ff.refresh == SW_PERIOD))
    else $error("boot refresh missing with protection disabled");
  AST_SHUTDOWN: assert property (
    en_low_s |=> (st_ff.state == ST_SHUTDOWN) && !st_ff.hs && !st_ff.ls && !ss_link.active)
    else $error("enable pin low did not hold shutdown");
  AST_STRETCH: assert property (
    stretch_fire |=> ##1 (st_ff.ls || !switching) [*8])
    else $error("third narrow low-side pulse not stretched");
  AST_NO_RESAMPLE: assert property (
    (st_ff.state != ST_SAMPLE) |=> $stable(st_ff.setpoint) && $stable(st_ff.ocp_en))
    else $error("trip level changed outside initialization");
  AST_BLANKING: assert property (
    $rose(st_ff.ls) |-> !oc_trip [*8])
    else $error("current sensed inside blanking time");
  AST_DUMMY_GATES: assert property (
    (st_ff.state == ST_DUMMY) |-> !st_ff.hs && !st_ff.ls)
    else $error("gate driven during retry delay");

  COV_RETRY_RAMP: cover property (st_ff.state == ST_DUMMY ##1 st_ff.state == ST_SOFTSTART);
  COV_REGULATE:   cover property (st_ff.state == ST_SOFTSTART ##1 st_ff.state == ST_REGULATE);
  COV_BOOT:       cover property (boot_fire);
  COV_STRETCH:    cover property (stretch_fire);

endmodule : ochr_top

// ==== tb/ochr_stage_model.sv ====
// Behavioural power stage: the low-side switch drop trips the comparator under a short
`timescale 1ns/1ps
module ochr_stage_model (
  input  wire logic clk_in,
  input  wire logic high_side_gate_in,
  input  wire logic low_side_gate_in,
  input  wire logic short_in,
  output logic      oc_cmp_out
);
  // The drop exists only while the low-side switch alone carries the shorted current
  always @(posedge clk_in) begin
    oc_cmp_out <= #1 short_in & low_side_gate_in & ~high_side_gate_in;
  end
endmodule : ochr_stage_model

// ==== tb/tb_top.sv ====
// Self-checking testbench of the overcurrent hiccup retry block
`timescale 1ns/1ps
module tb_top;
  import ochr_pkg::*;
  // ********************************************************************
  // Shortened counts, signals and the table of ordinary cases
  // ********************************************************************
  localparam int STEP   = 4;
  localparam int INITD  = 10;
  // Longer than three switching periods so the stretcher acts before refresh
  localparam int BOOTC  = 2000;
  localparam int SS_LEN = SS_STEPS * STEP;
  typedef struct {
    logic [MV_W-1:0] mv;
    logic            open;
    logic [MV_W-1:0] sp;
    logic            en;
  } ochr_tb_row_t;
  ochr_tb_row_t rows [7] = '{'{10'h000, 1'h0, 10'h000, 1'h1}, '{10'h064, 1'h0, 10'h0c8, 1'h1},
    '{10'h0ed, 1'h0, 10'h1da, 1'h1}, '{10'h0ee, 1'h0, 10'h1db, 1'h1},
    '{10'h12c, 1'h0, 10'h1db, 1'h1}, '{10'h12d, 1'h0, 10'h000, 1'h0},
    '{10'h064, 1'h1, 10'h000, 1'h0}};
  logic                clk_in, rst_in, pwm_in, oc_cmp_in, en_low_in, rbsoc_open_in, short_on;
  logic                hs, ls, src_en, ocp_en, reg_on, hic, pwm_free;
  logic [MV_W-1:0]     rbsoc_mv_in, sp;
  logic [SS_LVL_W-1:0] ss_ref, ss_prev;
  int                  num_errors, n_compared, pwm_cnt, n, bad;

  ochr_top #(.SS_STEP_CYCLES(STEP), .INIT_DELAY_CYCLES(INITD), .BOOT_ON_CYCLES(BOOTC)) u_ochr_top (
    .clk_in(clk_in), .rst_in(rst_in), .pwm_in(pwm_in), .oc_cmp_in(oc_cmp_in),
    .en_low_in(en_low_in), .rbsoc_open_in(rbsoc_open_in), .rbsoc_mv_in(rbsoc_mv_in),
    .high_side_gate_out(hs), .low_side_gate_out(ls), .ocp_set_current_source_en_out(src_en),
    .overcurrent_protect_en_out(ocp_en), .ocp_set_current_mv_out(sp), .ss_ref_out(ss_ref),
    .regulating_out(reg_on), .hiccup_out(hic));

  ochr_stage_model u_ochr_stage_model (.clk_in(clk_in), .high_side_gate_in(hs),
    .low_side_gate_in(ls), .short_in(short_on), .oc_cmp_out(oc_cmp_in));

  // ********************************************************************
  // Clock, PWM source and shared tasks
  // ********************************************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    pwm_cnt <= (pwm_cnt == 199) ? 0 : pwm_cnt + 1;
    pwm_in  <= #1 pwm_free | (pwm_cnt < 100);
  end

  // Each change of the reference must be a single step up, or a restart from zero
  // Sampled on the falling edge, where the registered reference has settled
  always @(negedge clk_in) begin
    if (!rst_in && ss_ref !== ss_prev && ss_ref !== '0) begin
      check("ramp step", SS_LVL_W'(ss_prev + 7'h01), ss_ref);
    end
    ss_prev <= ss_ref;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic wait_val(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      cyc(1);
      cnt++;
    end
  endtask : wait_val

  task automatic startup(input logic [MV_W-1:0] mv, input logic open, output int cnt);
    en_low_in = 1'b1;
    cyc(6);
    check("gates in shutdown", 32'h0, {hs, ls, reg_on, hic, src_en});
    rbsoc_mv_in   = mv;
    rbsoc_open_in = open;
    cyc(2);
    en_low_in = 1'b0;
    wait_val(src_en, 1'b1, 8, cnt);
    check("source on in init", 32'h1, src_en);
    wait_val(reg_on, 1'b1, INITD + SS_LEN + 30, cnt);
    check("source off in regulation", 32'h0, src_en);
  endtask : startup

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    $display("CHECK FAILED watchdog expected end of tests seen timeout");
    give_verdict();
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    rst_in        = 1'b1;
    en_low_in     = 1'b0;
    rbsoc_open_in = 1'b0;
    rbsoc_mv_in   = 10'h000;
    short_on      = 1'b0;
    pwm_free      = 1'b0;
    num_errors    = 0;
    n_compared    = 0;
    cyc(12);
    check("outputs in reset", 32'h0, {hs, ls, reg_on, hic, ocp_en, ss_ref});
    rst_in = 1'b0;
    foreach (rows[i]) begin
      startup(rows[i].mv, rows[i].open, n);
      check("start latency", 32'h1, n >= INITD + SS_LEN && n <= INITD + SS_LEN + 12);
      check("protect enable", rows[i].en, ocp_en);
      if (rows[i].en) check("trip level", rows[i].sp, sp);
      check("full reference", SS_FULL, ss_ref);
    end
    // Short applied while the high side conducts, so the trip waits for a fresh low pulse
    startup(10'h064, 1'b0, n);
    while (pwm_in !== 1'b1) cyc(1);
    cyc(5);
    short_on = 1'b1;
    wait_val(ls, 1'b1, 300, n);
    wait_val(hic, 1'b1, 60, n);
    check("trip after blanking", 32'h1, n >= BLANK_CYC && n <= BLANK_CYC + 6);
    check("output off on trip", 32'h0, {hs, ls, reg_on});
    rbsoc_mv_in = 10'h032;
    n = 0;
    bad = 0;
    while (hic === 1'b1 && n < 2 * SS_LEN + 10) begin
      if (hs !== 1'b0 || ls !== 1'b0) bad++;
      cyc(1);
      n++;
    end
    check("dummy delay length", 2 * SS_LEN, n);
    check("gates held in delays", 32'h0, bad);
    wait_val(hic, 1'b1, SS_LEN + 20, n);
    check("retrip in real ramp", 32'h1, n < SS_LEN);
    short_on = 1'b0;
    wait_val(reg_on, 1'b1, 3 * SS_LEN + 40, n);
    check("recovered", 32'h2, {reg_on, hic});
    check("trip level kept", 10'h0c8, sp);
    pwm_free = 1'b1;
    cyc(6);
    wait_val(ls, 1'b1, 1500, n);
    wait_val(ls, 1'b0, 400, n);
    check("stretched pulse", LS_MIN_CYC, n);
    startup(10'h064, 1'b1, n);
    cyc(6);
    wait_val(ls, 1'b1, BOOTC + 40, n);
    // The high side has been on since the ramp began, a ramp length before regulation
    check("refresh delay", 32'h1, n >= BOOTC - SS_LEN - 16 && n <= BOOTC - SS_LEN + 4);
    wait_val(ls, 1'b0, 400, n);
    check("refresh width", SW_PERIOD_CYC, n);
    give_verdict();
  end
endmodule : tb_top
